// ---- hw/bsc_pkg.sv ----
// Purpose: Shared constants and types for the bit-test, bit-set and call unit
// Assumes: 14-bit instruction words, 13-bit program counter, 8-bit file data
// Notes:   All field positions and opcode patterns live here
package bsc_pkg;

   // Widths
   localparam int INSTR_W = 14;
   localparam int PC_W    = 13;
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 7;
   localparam int BIT_W   = 3;
   localparam int LIT_W   = 11;
   localparam int UAL_W   = 8;

   // Hardware stack shape
   localparam int STK_DEPTH = 8;
   localparam int STK_PTR_W = 3;

   // Instruction cycle phases, one clk_sys each
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   localparam logic [1:0] PH_STEP = 2'h1;

   // Bit-oriented word fields
   localparam int BO_CLASS_HI = 13;
   localparam int BO_CLASS_LO = 12;
   localparam int BO_SUB_HI   = 11;
   localparam int BO_SUB_LO   = 10;
   localparam int BO_BIT_HI   = 9;
   localparam int BO_BIT_LO   = 7;
   localparam int BO_ADDR_HI  = 6;
   localparam int BO_ADDR_LO  = 0;
   localparam logic [1:0] BO_CLASS     = 2'h1;
   localparam logic [1:0] BO_SUB_SKCLR = 2'h2;
   localparam logic [1:0] BO_SUB_SET   = 2'h1;
   localparam logic [1:0] BO_SUB_SKSET = 2'h3;

   // Call word fields
   localparam int CALL_OP_HI = 13;
   localparam int CALL_OP_LO = 11;
   localparam int CALL_K_HI  = 10;
   localparam int CALL_K_LO  = 0;
   localparam logic [2:0] CALL_OP = 3'h4;

   // Upper address latch bits copied into the program counter
   localparam int UAL_HI = 4;
   localparam int UAL_LO = 3;

   // Return address offset and reset values
   localparam logic [PC_W-1:0]   PC_INC     = 13'h0001;
   localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
   localparam logic [DATA_W-1:0] DATA_RST   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST   = 7'h00;
   localparam logic [BIT_W-1:0]  BIT_RST    = 3'h0;
   localparam logic [LIT_W-1:0]  LIT_RST    = 11'h000;
   localparam logic [UAL_W-1:0]  UAL_RST    = 8'h00;
   localparam logic [STK_PTR_W-1:0] PTR_RST = 3'h0;
   localparam logic [STK_PTR_W-1:0] PTR_STEP = 3'h1;
   localparam logic [DATA_W-1:0] MASK_ONE   = 8'h01;

   // Sequencer states and decoded operations
   typedef enum logic [0:0] {bsc_st_exec, bsc_st_nop} bsc_state_e;
   typedef enum logic [2:0] {bsc_op_none, bsc_op_skclr, bsc_op_set,
                             bsc_op_skset, bsc_op_call} bsc_op_e;

endpackage

// ---- hw/bsc_stack.sv ----
// Purpose: Eight-level return address stack
// Assumes: One push at a time; overflow wraps and overwrites the oldest
// Notes:   Top of stack comes out of a register
`timescale 1ns/1ps
module bsc_stack (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // Push side
   input  wire logic                        push,
   input  wire logic [bsc_pkg::PC_W-1:0]    push_data,
   // Top entry
   output logic      [bsc_pkg::PC_W-1:0]    top
);

   logic [bsc_pkg::PC_W-1:0]      mem [bsc_pkg::STK_DEPTH];
   logic [bsc_pkg::STK_PTR_W-1:0] ptr;
   logic [bsc_pkg::STK_PTR_W-1:0] next_ptr;
   logic [bsc_pkg::PC_W-1:0]      next_top;

   // Pointer and top follow each push
   always_comb begin
      next_ptr = ptr;
      next_top = mem[bsc_pkg::STK_PTR_W'(ptr - bsc_pkg::PTR_STEP)]; // Newest stored entry
      if (push) begin
         next_ptr = bsc_pkg::STK_PTR_W'(ptr + bsc_pkg::PTR_STEP);
         next_top = push_data;
      end
   end

   // State registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ptr <= bsc_pkg::PTR_RST;
         top <= bsc_pkg::PC_RST;
      end else begin
         ptr <= next_ptr;
         top <= next_top;
      end
   end

   // Storage array, cleared so the top read is defined after reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < bsc_pkg::STK_DEPTH; i++) begin
            mem[i] <= bsc_pkg::PC_RST;
         end
      end else if (push) begin
         mem[ptr] <= push_data;
      end
   end

endmodule

// ---- hw/bsc_exec.sv ----
// Purpose: Executes bit-test-skip, bit-force-one and subroutine call words
// Assumes: Four clk_sys per instruction cycle (Q1..Q4); file read data
//          arrive one clk after the read strobe
// Notes:   Other opcodes pass through as one-cycle no-ops in this unit
`timescale 1ns/1ps
// What this block does
// [RL1] Skip-if-clear test: bit 0 discards next word, runs one no-op cycle.
// [RL2] Bit-force-one: read, OR in the selected bit, write back; flags untouched.
// [RL3] Skip-if-set test: bit 1 discards next word and runs a no-op instead.
// [RL4] Call pushes current program counter plus one as new stack top.
// [RL5] Call loads 11-bit literal into PC 10:0, latch bits 4:3 into 12:11.
// [RL6] Call takes two cycles; the second one is a no-op.
// [RL7] Bit words: index from bits 9:7, address from 6:0, bits 13:12 are 01.
module bsc_exec (
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rst_n,
   // Fetched word and program counter context
   input  wire logic [bsc_pkg::INSTR_W-1:0]    instr_word,
   input  wire logic [bsc_pkg::PC_W-1:0]       pc_cur,
   input  wire logic [bsc_pkg::UAL_W-1:0]      upper_address_latch,
   // File register port
   output logic      [bsc_pkg::ADDR_W-1:0]     file_addr,
   output logic                                file_rd_en,
   input  wire logic [bsc_pkg::DATA_W-1:0]     file_rd_data,
   output logic                                file_wr_en,
   output logic      [bsc_pkg::DATA_W-1:0]     file_wr_data,
   // Program counter load
   output logic                                pc_load,
   output logic      [bsc_pkg::PC_W-1:0]       pc_value,
   // Stack and sequencing status
   output logic      [bsc_pkg::PC_W-1:0]       stack_top_entry,
   output logic                                stack_push,
   output logic                                skip_taken,
   output logic                                nop_cycle,
   output logic      [1:0]                     phase
);

   // Decode of one word into an operation
   function automatic bsc_pkg::bsc_op_e decode_op(input logic [bsc_pkg::INSTR_W-1:0] w);
      decode_op = bsc_pkg::bsc_op_none;
      if (w[bsc_pkg::CALL_OP_HI:bsc_pkg::CALL_OP_LO] == bsc_pkg::CALL_OP) begin
         decode_op = bsc_pkg::bsc_op_call;
      end else if (w[bsc_pkg::BO_CLASS_HI:bsc_pkg::BO_CLASS_LO] == bsc_pkg::BO_CLASS) begin
         unique case (w[bsc_pkg::BO_SUB_HI:bsc_pkg::BO_SUB_LO])
            bsc_pkg::BO_SUB_SKCLR: decode_op = bsc_pkg::bsc_op_skclr;
            bsc_pkg::BO_SUB_SET:   decode_op = bsc_pkg::bsc_op_set;
            bsc_pkg::BO_SUB_SKSET: decode_op = bsc_pkg::bsc_op_skset;
            default:               decode_op = bsc_pkg::bsc_op_none;
         endcase
      end
   endfunction

   // One-hot mask for a bit index
   function automatic logic [bsc_pkg::DATA_W-1:0] bit_mask(input logic [bsc_pkg::BIT_W-1:0] b);
      bit_mask = bsc_pkg::DATA_W'(bsc_pkg::MASK_ONE << b);
   endfunction

   bsc_pkg::bsc_state_e             state;
   bsc_pkg::bsc_state_e             next_state;
   bsc_pkg::bsc_op_e                op;
   bsc_pkg::bsc_op_e                next_op;
   logic [bsc_pkg::BIT_W-1:0]       bit_idx;
   logic [bsc_pkg::BIT_W-1:0]       next_bit_idx;
   logic [bsc_pkg::LIT_W-1:0]       literal;
   logic [bsc_pkg::LIT_W-1:0]       next_literal;
   logic [bsc_pkg::PC_W-1:0]        pc_ret;
   logic [bsc_pkg::PC_W-1:0]        next_pc_ret;
   logic [1:0]                      next_phase;
   logic [bsc_pkg::ADDR_W-1:0]      next_file_addr;
   logic                            next_file_rd_en;
   logic                            next_file_wr_en;
   logic [bsc_pkg::DATA_W-1:0]      next_file_wr_data;
   logic                            next_pc_load;
   logic [bsc_pkg::PC_W-1:0]        next_pc_value;
   logic                            next_stack_push;
   logic                            next_skip_taken;
   logic                            next_nop_cycle;
   logic                            bit_val;

   assign bit_val = file_rd_data[bit_idx];

   // Phase sequencing, decode and execution
   always_comb begin
      next_phase        = 2'(phase + bsc_pkg::PH_STEP);
      next_state        = state;
      next_op           = op;
      next_bit_idx      = bit_idx;
      next_literal      = literal;
      next_pc_ret       = pc_ret;
      next_file_addr    = file_addr;
      next_file_rd_en   = 1'b0;
      next_file_wr_en   = 1'b0;
      next_file_wr_data = file_wr_data;
      next_pc_load      = 1'b0;
      next_pc_value     = pc_value;
      next_stack_push   = 1'b0;
      next_skip_taken   = 1'b0;
      next_nop_cycle    = nop_cycle;
      unique case (phase)
         bsc_pkg::PH_Q1: begin
            if (state == bsc_pkg::bsc_st_nop) begin
               // Discarded word: whole cycle is a no-op
               next_op        = bsc_pkg::bsc_op_none; // RL1 RL3 RL6
               next_nop_cycle = 1'b1;
               next_state     = bsc_pkg::bsc_st_exec;
            end else begin
               next_op        = decode_op(instr_word);
               next_nop_cycle = 1'b0;
               next_bit_idx   = instr_word[bsc_pkg::BO_BIT_HI:bsc_pkg::BO_BIT_LO]; // RL7
               next_file_addr = instr_word[bsc_pkg::BO_ADDR_HI:bsc_pkg::BO_ADDR_LO]; // RL7
               next_literal   = instr_word[bsc_pkg::CALL_K_HI:bsc_pkg::CALL_K_LO];
               next_pc_ret    = bsc_pkg::PC_W'(pc_cur + bsc_pkg::PC_INC); // RL4
               next_file_rd_en = (decode_op(instr_word) != bsc_pkg::bsc_op_none) &&
                                 (decode_op(instr_word) != bsc_pkg::bsc_op_call); // RL7
            end
         end
         bsc_pkg::PH_Q2: begin
            // Read strobe is out; data arrive during Q3
         end
         bsc_pkg::PH_Q3: begin
            unique case (op)
               bsc_pkg::bsc_op_set: begin
                  next_file_wr_en   = 1'b1; // RL2
                  next_file_wr_data = file_rd_data | bit_mask(bit_idx); // RL2
               end
               bsc_pkg::bsc_op_skclr: begin
                  if (!bit_val) begin
                     next_skip_taken = 1'b1; // RL1
                     next_state      = bsc_pkg::bsc_st_nop; // RL1
                  end
               end
               bsc_pkg::bsc_op_skset: begin
                  if (bit_val) begin
                     next_skip_taken = 1'b1; // RL3
                     next_state      = bsc_pkg::bsc_st_nop; // RL3
                  end
               end
               bsc_pkg::bsc_op_call: begin
                  next_stack_push = 1'b1; // RL4
                  next_pc_load    = 1'b1; // RL5
                  next_pc_value   = {upper_address_latch[bsc_pkg::UAL_HI:bsc_pkg::UAL_LO],
                                     literal}; // RL5
                  next_state      = bsc_pkg::bsc_st_nop; // RL6
               end
               bsc_pkg::bsc_op_none: begin
               end
            endcase
         end
         bsc_pkg::PH_Q4: begin
         end
      endcase
   end

   // Registers of the sequencer and all outputs except stack_top_entry
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase        <= bsc_pkg::PH_Q1;
         state        <= bsc_pkg::bsc_st_exec;
         op           <= bsc_pkg::bsc_op_none;
         bit_idx      <= bsc_pkg::BIT_RST;
         literal      <= bsc_pkg::LIT_RST;
         pc_ret       <= bsc_pkg::PC_RST;
         file_addr    <= bsc_pkg::ADDR_RST;
         file_rd_en   <= 1'b0;
         file_wr_en   <= 1'b0;
         file_wr_data <= bsc_pkg::DATA_RST;
         pc_load      <= 1'b0;
         pc_value     <= bsc_pkg::PC_RST;
         stack_push   <= 1'b0;
         skip_taken   <= 1'b0;
         nop_cycle    <= 1'b0;
      end else begin
         phase        <= next_phase;
         state        <= next_state;
         op           <= next_op;
         bit_idx      <= next_bit_idx;
         literal      <= next_literal;
         pc_ret       <= next_pc_ret;
         file_addr    <= next_file_addr;
         file_rd_en   <= next_file_rd_en;
         file_wr_en   <= next_file_wr_en;
         file_wr_data <= next_file_wr_data;
         pc_load      <= next_pc_load;
         pc_value     <= next_pc_value;
         stack_push   <= next_stack_push;
         skip_taken   <= next_skip_taken;
         nop_cycle    <= next_nop_cycle;
      end
   end

   // Return address stack
   bsc_stack u_stack (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .push      (stack_push),
      .push_data (pc_ret),
      .top       (stack_top_entry)
   );

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence skip_then_nop;
      skip_taken ##2 nop_cycle;
   endsequence

   sequence no_skip_run;
      !skip_taken ##2 !nop_cycle;
   endsequence

   skip_clear_a: assert property ((phase == bsc_pkg::PH_Q3) && (op == bsc_pkg::bsc_op_skclr) // RL1
      |-> if (!bit_val) (##1 skip_then_nop) else (##1 no_skip_run))
      else $error("skip-if-clear outcome wrong");

   skip_set_a: assert property ((phase == bsc_pkg::PH_Q3) && (op == bsc_pkg::bsc_op_skset) // RL3
      |-> if (bit_val) (##1 skip_then_nop) else (##1 no_skip_run))
      else $error("skip-if-set outcome wrong");

   bit_force_a: assert property ((phase == bsc_pkg::PH_Q3) && (op == bsc_pkg::bsc_op_set) // RL2
      |=> file_wr_en && (file_wr_data == ($past(file_rd_data) | bit_mask(bit_idx)))
          && !skip_taken && !pc_load)
      else $error("bit force write-back wrong");

   call_push_a: assert property ((phase == bsc_pkg::PH_Q3) && (op == bsc_pkg::bsc_op_call) // RL4
      |=> stack_push ##1 (stack_top_entry == $past(pc_ret)))
      else $error("call return address not on stack");

   call_target_a: assert property ((phase == bsc_pkg::PH_Q3) && (op == bsc_pkg::bsc_op_call) // RL5
      |=> pc_load && (pc_value == {$past(upper_address_latch[bsc_pkg::UAL_HI:bsc_pkg::UAL_LO]),
                                   $past(literal)}))
      else $error("call target wrong");

   call_two_a: assert property ((phase == bsc_pkg::PH_Q3) && (op == bsc_pkg::bsc_op_call) // RL6
      |=> !nop_cycle ##2 nop_cycle [*4])
      else $error("call second cycle is not a no-op");

   bit_decode_a: assert property ((phase == bsc_pkg::PH_Q1) && (state == bsc_pkg::bsc_st_exec) // RL7
      && (instr_word[bsc_pkg::BO_CLASS_HI:bsc_pkg::BO_CLASS_LO] == bsc_pkg::BO_CLASS)
      && (instr_word[bsc_pkg::BO_SUB_HI:bsc_pkg::BO_SUB_LO] != 2'h0)
      |=> file_rd_en && (file_addr == $past(instr_word[bsc_pkg::BO_ADDR_HI:bsc_pkg::BO_ADDR_LO]))
          && (bit_idx == $past(instr_word[bsc_pkg::BO_BIT_HI:bsc_pkg::BO_BIT_LO])))
      else $error("bit word fields decoded wrong");

   nop_quiet_a: assert property (nop_cycle |-> !file_wr_en && !pc_load && !stack_push) // RL6
      else $error("activity during a no-op cycle");

endmodule

// ---- dv/tb_bit_skip_call_exec.sv ----
// Purpose: Self-checking bench for the bit-test, bit-force-one and call unit
// Assumes: One clk_sys per Q phase; file read data given 1 ns after the strobe rises, held through Q3
// Notes:   Inputs change 1 ns after the rising edge; words are driven back to back
`timescale 1ns/1ps
module tb_bit_skip_call_exec;
   // Clock, reset and stimulus
   logic                              clk_sys;
   logic                              rst_n;
   logic [bsc_pkg::INSTR_W-1:0]       instr_word;
   logic [bsc_pkg::PC_W-1:0]          pc_cur;
   logic [bsc_pkg::UAL_W-1:0]         upper_address_latch;
   logic [bsc_pkg::DATA_W-1:0]        file_rd_data;
   // Observed outputs
   logic [bsc_pkg::ADDR_W-1:0]        file_addr;
   logic [bsc_pkg::DATA_W-1:0]        file_wr_data;
   logic [bsc_pkg::PC_W-1:0]          pc_value;
   logic [bsc_pkg::PC_W-1:0]          stack_top_entry;
   logic [1:0]                        phase;
   logic file_rd_en, file_wr_en, pc_load, stack_push, skip_taken, nop_cycle;
   // Report counters
   int                                mismatches = 0;
   int                                total_checks = 0;

   // Device under test
   bsc_exec u_dut (
      .clk_sys             (clk_sys),
      .rst_n               (rst_n),
      .instr_word          (instr_word),
      .pc_cur              (pc_cur),
      .upper_address_latch (upper_address_latch),
      .file_addr           (file_addr),
      .file_rd_en          (file_rd_en),
      .file_rd_data        (file_rd_data),
      .file_wr_en          (file_wr_en),
      .file_wr_data        (file_wr_data),
      .pc_load             (pc_load),
      .pc_value            (pc_value),
      .stack_top_entry     (stack_top_entry),
      .stack_push          (stack_push),
      .skip_taken          (skip_taken),
      .nop_cycle           (nop_cycle),
      .phase               (phase)
   );

   // 125 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Prints the check totals and the verdict, then stops
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One comparison
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   // Runs one word through Q1..Q4 and any discarded follow-on cycle
   task automatic do_word(input logic [13:0] w, input logic [12:0] pc,
                          input logic [7:0] ual, input logic [7:0] rd);
      logic       is_bit, is_call, exp_rd, exp_skip, exp_wr, exp_nop;
      logic [2:0] b;
      int         n;
      is_bit   = (w[13:12] == 2'h1);
      is_call  = (w[13:11] == 3'h4);
      b        = w[9:7];
      exp_rd   = is_bit && (w[11:10] != 2'h0);
      exp_skip = is_bit && ((w[11:10] == 2'h2 && !rd[b]) || (w[11:10] == 2'h3 && rd[b]));
      exp_wr   = is_bit && (w[11:10] == 2'h1);
      exp_nop  = exp_skip || is_call;
      n = 0;
      while (phase !== 2'h0) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > 8) begin
            mismatches++;
            $display("Error at %0t: phase never returned to Q1", $time);
            give_verdict();
         end
      end
      instr_word = w;
      pc_cur = pc;
      upper_address_latch = ual;
      @(posedge clk_sys);
      #1;
      chk(file_rd_en === exp_rd && phase === 2'h1, "read strobe in Q2");
      if (exp_rd) chk(file_addr === w[6:0], "file address field");
      chk(nop_cycle === 1'b0, "no-op flag in a normal cycle");
      file_rd_data = rd;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(skip_taken === exp_skip, "skip decision");
      chk(file_wr_en === exp_wr, "write strobe in Q4");
      if (exp_wr) chk(file_wr_data === (rd | (8'h01 << b)), "written data");
      chk(pc_load === is_call && stack_push === is_call, "call strobes");
      if (is_call) chk(pc_value === {ual[4:3], w[10:0]}, "call target");
      file_rd_data = ~rd;
      @(posedge clk_sys);
      #1;
      if (is_call) chk(stack_top_entry === pc + 13'h0001, "return address");
      if (exp_nop) begin
         instr_word = 14'h17ff; // Would force a bit if it were not discarded
         repeat (4) begin
            @(posedge clk_sys);
            #1;
            chk(nop_cycle === 1'b1 && file_rd_en === 1'b0 && pc_load === 1'b0 &&
                file_wr_en === 1'b0 && stack_push === 1'b0,
                "discarded word cycle");
         end
      end
   endtask

   // Skip-if-clear with the bit clear and then set, every index
   task automatic t_skip_clear();
      for (int i = 0; i < 8; i++) begin
         do_word({2'h1, 2'h2, i[2:0], 7'h05}, 13'h0100 + 13'(i), 8'h00, ~(8'h01 << i));
         do_word({2'h1, 2'h2, i[2:0], 7'h7f}, 13'h0200, 8'h00, 8'h01 << i);
      end
   endtask

   // Skip-if-set with the bit set and then clear, every index
   task automatic t_skip_set();
      for (int i = 0; i < 8; i++) begin
         do_word({2'h1, 2'h3, i[2:0], 7'h00}, 13'h0300, 8'h00, 8'h01 << i);
         do_word({2'h1, 2'h3, i[2:0], 7'h2a}, 13'h0301, 8'h00, ~(8'h01 << i));
      end
   endtask

   // Bit-force-one on clear, mixed and already-set data
   task automatic t_bit_set();
      for (int i = 0; i < 8; i++) begin
         do_word({2'h1, 2'h1, i[2:0], 7'(i * 17)}, 13'h0400, 8'h00, 8'h00);
         do_word({2'h1, 2'h1, i[2:0], 7'h7f}, 13'h0401, 8'h00, 8'ha5);
      end
   endtask

   // Back-to-back calls at the edges of the literal and address range
   task automatic t_call();
      do_word({3'h4, 11'h7ff}, 13'h1fff, 8'h18, 8'h00);
      do_word({3'h4, 11'h000}, 13'h0000, 8'he7, 8'h00);
      do_word({3'h4, 11'h555}, 13'h0abc, 8'h08, 8'h00);
      do_word({3'h4, 11'h2aa}, 13'h1234, 8'h10, 8'h00);
   endtask

   // Words outside this unit leave every strobe low
   task automatic t_inert();
      do_word({2'h1, 2'h0, 3'h7, 7'h12}, 13'h0500, 8'h00, 8'h00);
      do_word({2'h0, 12'hfff}, 13'h0501, 8'h00, 8'hff);
      do_word({2'h3, 12'h0ff}, 13'h0502, 8'h00, 8'hff);
      do_word({3'h5, 11'h7ff}, 13'h0503, 8'h18, 8'h00);
   endtask

   // Reset in the middle of a call, then a clean restart
   task automatic t_reset_mid();
      do_word({2'h1, 2'h1, 3'h0, 7'h01}, 13'h0600, 8'h00, 8'h00);
      instr_word = {3'h4, 11'h123};
      @(posedge clk_sys);
      #1;
      rst_n = 1'b0;
      #1;
      chk(phase === 2'h0 && pc_load === 1'b0 && file_rd_en === 1'b0 && nop_cycle === 1'b0,
          "outputs cleared by reset");
      repeat (2) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      do_word({2'h1, 2'h1, 3'h4, 7'h33}, 13'h0700, 8'h00, 8'h0f);
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      instr_word = 14'h0000;
      pc_cur = 13'h0000;
      upper_address_latch = 8'h00;
      file_rd_data = 8'h00;
      repeat (8) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      t_skip_clear();
      t_skip_set();
      t_bit_set();
      t_call();
      t_inert();
      t_reset_mid();
      give_verdict();
   end
endmodule
